/* logic/tu_pkg.sv */
`default_nettype none
package tu_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_MAIN = 8'h00;
  localparam logic [7:0] OFF_SETB_CLR = 8'h04;
  localparam logic [7:0] OFF_SETB_SET = 8'h08;
  localparam logic [7:0] OFF_SETC = 8'h0c;
  localparam logic [7:0] OFF_EVSET = 8'h10;
  localparam logic [7:0] OFF_FLAG = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_COUNT = 8'h20;
  localparam logic [7:0] OFF_TOP = 8'h24;
  localparam logic [7:0] OFF_MATCH0 = 8'h28;
  localparam logic [7:0] OFF_MATCH1 = 8'h2c;
  localparam logic [7:0] OFF_HALT = 8'h30;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int M_SOFT_RESET_TRIGGER = 0;
  localparam int M_EN = 1;
  localparam int M_MODE = 2;
  localparam int M_WAVE = 5;
  localparam int M_PRE = 8;
  localparam int M_ASLEEP = 11;
  localparam int M_PRESYNC = 12;
  localparam int B_DIR = 0;
  localparam int B_SINGLE_RUN_SELECT = 2;
  localparam int B_CMD = 6;
  localparam int C_FLIP = 0;
  localparam int C_GRAB = 4;
  localparam int E_ACT = 0;
  localparam int E_IN_EN = 4;
  localparam int E_WRAP_OE = 8;
  localparam int E_MATCH_OE = 12;
  localparam int F_WRAP = 0;
  localparam int F_MATCH = 4;
  localparam int S_STOP = 3;
  localparam int S_BUSY = 7;
  // ----------------------------------------
  // encodings and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_16 = 2'h0;
  localparam logic [1:0] MODE_8 = 2'h1;
  localparam logic [1:0] MODE_32 = 2'h2;
  localparam logic [1:0] WG_NFRQ = 2'h0;
  localparam logic [1:0] WG_MFRQ = 2'h1;
  localparam logic [1:0] WG_NPWM = 2'h2;
  localparam logic [1:0] WG_MPWM = 2'h3;
  localparam logic [1:0] CMD_RETRIG = 2'h1;
  localparam logic [1:0] CMD_STOP = 2'h2;
  localparam logic [2:0] ACT_OFF = 3'h0;
  localparam logic [2:0] ACT_RETRIG = 3'h1;
  localparam logic [2:0] ACT_COUNT = 3'h2;
  localparam logic [2:0] ACT_START = 3'h3;
  localparam logic [2:0] ACT_CAPT = 3'h4;
  localparam logic [31:0] MASK8 = 32'h0000_00ff;
  localparam logic [31:0] MASK16 = 32'h0000_ffff;
  localparam logic [31:0] MASK32 = 32'hffff_ffff;
  localparam logic [31:0] TOP_RST = 32'h0000_00ff;
  localparam int PRE_W = 10;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic dbg;
  } tu_bus_req_t;
  typedef enum {CS_OFF, CS_WAIT, CS_RUN} tu_cstate_t;
endpackage : tu_pkg
`default_nettype wire

/* logic/tu_tally_unit.sv */
// Function
// - count events or prescaled counting clock
// - prescaler divides counting clock
// - width selectable 8, 16, 32 bits
// - reset width is 16 bits
// - default up-count, wraps to zero
// - compare match toggles two shaped outputs
// - capture channels record counter on events
// - main setup locked while enabled, some bits
// - trigger action field locked while enabled
// - locked bits write while disabled, also with enable rising
// - each shaped output invertible by polarity flip
// - debug halt stops unless halt register keeps
// - write guard protects setup registers only, top excluded
// - debug halt lifts write guard
// - debugger accesses bypass write guard
// - paired units share one counting clock
// - counting clock synchronised into bus clock
// - runs asleep if kept
// - interrupt, events on wrap, match; dma on wrap, capture 0
// - prescaler ratios from 1 to 1024
// - top or zero sets wrap flag
// - soft reset clears all but halt register
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tu_tally_unit #(
  parameter int NCH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire tu_pkg::tu_bus_req_t bus,
  output logic [31:0] rd_data,
  input wire logic core_count_clock,
  input wire logic trig_event_in,
  input wire logic write_guard_on,
  input wire logic debug_halted,
  input wire logic sleep_active,
  output logic [NCH-1:0] shaped_output_pin,
  output logic irq,
  output logic dma_req,
  output logic evt_wrap_out,
  output logic [NCH-1:0] evt_match_out
);
  import tu_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic en, keep_asleep, presync, dir, single_run_select, ev_in_en, wrap_oe, dbg_keep;
  logic [1:0] mode, wavegen;
  logic [2:0] presc, act;
  logic [NCH-1:0] flip, grab, match_oe, wave, match_flag;
  logic wrap_flag, stop_st;
  logic [31:0] cnt, top_limit;
  logic [NCH-1:0][31:0] mgrab;
  logic [PRE_W-1:0] pre_cnt;
  logic cc_s1, cc_s2, cc_s3;
  logic en_s1, en_s2, en_s3;
  tu_cstate_t cs, next_cs;

  // ----------------------------------------
  // bus decode and protection
  // ----------------------------------------
  wire guard_ok = !write_guard_on || debug_halted || bus.dbg;
  wire [31:0] wd = bus.wdata;
  wire w_main = bus.wr && bus.addr == OFF_MAIN && guard_ok;
  wire w_bclr = bus.wr && bus.addr == OFF_SETB_CLR && guard_ok;
  wire w_bset = bus.wr && bus.addr == OFF_SETB_SET && guard_ok;
  wire w_setc = bus.wr && bus.addr == OFF_SETC && guard_ok;
  wire w_evset = bus.wr && bus.addr == OFF_EVSET && guard_ok;
  wire w_halt = bus.wr && bus.addr == OFF_HALT && guard_ok;
  wire w_flag = bus.wr && bus.addr == OFF_FLAG;
  wire w_count = bus.wr && bus.addr == OFF_COUNT;
  wire w_top = bus.wr && bus.addr == OFF_TOP;
  wire soft_reset_trigger = w_main && wd[M_SOFT_RESET_TRIGGER];
  wire prot_ok = !en && !en_s2;
  wire [1:0] cmd = w_bset ? wd[B_CMD+:2] : 2'h0;
  wire sw_retrig = cmd == CMD_RETRIG;
  wire sw_stop = cmd == CMD_STOP;

  // ----------------------------------------
  // clock crossing and stall
  // ----------------------------------------
  wire cc_edge = cc_s2 && !cc_s3;
  wire en_rise = en_s2 && !en_s3;
  wire busy = en ^ en_s2;
  wire stall = (debug_halted && !dbg_keep) || (sleep_active && !keep_asleep);

  // ----------------------------------------
  // width and top
  // ----------------------------------------
  wire [31:0] wmask = mode == MODE_8 ? MASK8 : (mode == MODE_32 ? MASK32 : MASK16);
  wire match_top = wavegen == WG_MFRQ || wavegen == WG_MPWM;
  wire [31:0] top_val = match_top ? mgrab[0] & wmask
                      : (mode == MODE_8 ? top_limit & MASK8 : wmask);

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  logic [PRE_W-1:0] ratio_m1;
  always_comb begin
    case (presc)
      3'h0: ratio_m1 = 10'h000;
      3'h1: ratio_m1 = 10'h001;
      3'h2: ratio_m1 = 10'h003;
      3'h3: ratio_m1 = 10'h007;
      3'h4: ratio_m1 = 10'h00f;
      3'h5: ratio_m1 = 10'h03f;
      3'h6: ratio_m1 = 10'h0ff;
      default: ratio_m1 = 10'h3ff;
    endcase
  end
  wire pre_hit = cc_edge && pre_cnt >= ratio_m1;

  // ----------------------------------------
  // counter control
  // ----------------------------------------
  wire running = cs == CS_RUN;
  wire ev_fire = ev_in_en && trig_event_in;
  wire cnt_src = act == ACT_COUNT ? ev_fire : pre_hit;
  wire step = running && cnt_src && !stall;
  wire at_end = dir ? cnt == 32'h0 : cnt >= top_val;
  wire wrap = step && at_end;
  wire retrig_ev = ev_fire && act == ACT_RETRIG;
  wire start_ev = ev_fire && (act == ACT_RETRIG || act == ACT_START);
  wire restart = running && !stall && (retrig_ev || sw_retrig);
  wire cap_ev = ev_fire && act == ACT_CAPT && running && !stall;
  wire [31:0] wrap_val = dir ? top_val : 32'h0;
  wire [31:0] step_val = dir ? cnt - 32'h1 : cnt + 32'h1;

  always_comb begin
    next_cs = cs;
    case (cs)
      CS_OFF: begin
        if (en_rise) begin
          next_cs = (act == ACT_RETRIG || act == ACT_START) ? CS_WAIT : CS_RUN;
        end
      end
      CS_WAIT: begin
        if (!en_s2) begin
          next_cs = CS_OFF;
        end else if (start_ev || sw_retrig) begin
          next_cs = CS_RUN;
        end
      end
      CS_RUN: begin
        if (!en_s2) begin
          next_cs = CS_OFF;
        end else if (sw_stop || (wrap && single_run_select)) begin
          next_cs = CS_WAIT;
        end
      end
      default: next_cs = CS_OFF;
    endcase
    if (soft_reset_trigger) begin
      next_cs = CS_OFF;
    end
  end

  logic [31:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (soft_reset_trigger) begin
      next_cnt = 32'h0;
    end else if (w_count) begin
      next_cnt = wd & wmask;
    end else if (restart) begin
      next_cnt = wrap_val;
    end else if (cap_ev && grab[0]) begin
      next_cnt = 32'h0;
    end else if (step) begin
      next_cnt = wrap ? wrap_val : step_val & wmask;
    end
  end

  // ----------------------------------------
  // per channel compare, capture, waveform
  // ----------------------------------------
  logic [NCH-1:0] hit, capt, next_wave, next_mflag;
  logic [NCH-1:0][31:0] next_mgrab;
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      wire [7:0] moff = OFF_MATCH0 + 8'(4 * i);
      wire w_match = bus.wr && bus.addr == moff;
      wire pwm = wavegen == WG_NPWM || (wavegen == WG_MPWM && i != 0);
      wire tog_wrap = match_top && i == 0 && wrap;
      assign hit[i] = step && !grab[i] && next_cnt == mgrab[i];
      assign capt[i] = cap_ev && grab[i];
      assign next_mgrab[i] = soft_reset_trigger ? 32'h0 : (w_match ? wd & wmask
                           : (capt[i] ? cnt : mgrab[i]));
      assign next_wave[i] = (soft_reset_trigger || sw_stop || cs == CS_OFF) ? 1'b0
                          : (pwm ? next_cnt < mgrab[i]
                          : wave[i] ^ (tog_wrap || (hit[i] && !match_top) ||
                                       (hit[i] && i != 0)));
      assign next_mflag[i] = soft_reset_trigger ? 1'b0 : (hit[i] || capt[i] ||
                             (match_flag[i] && !(w_flag && wd[F_MATCH + i])));
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    case (bus.addr)
      OFF_MAIN: begin
        next_rdata[M_EN] = en;
        next_rdata[M_MODE+:2] = mode;
        next_rdata[M_WAVE+:2] = wavegen;
        next_rdata[M_PRE+:3] = presc;
        next_rdata[M_ASLEEP] = keep_asleep;
        next_rdata[M_PRESYNC] = presync;
      end
      OFF_SETB_CLR, OFF_SETB_SET: begin
        next_rdata[B_DIR] = dir;
        next_rdata[B_SINGLE_RUN_SELECT] = single_run_select;
      end
      OFF_SETC: begin
        next_rdata[C_FLIP+:NCH] = flip;
        next_rdata[C_GRAB+:NCH] = grab;
      end
      OFF_EVSET: begin
        next_rdata[E_ACT+:3] = act;
        next_rdata[E_IN_EN] = ev_in_en;
        next_rdata[E_WRAP_OE] = wrap_oe;
        next_rdata[E_MATCH_OE+:NCH] = match_oe;
      end
      OFF_FLAG: begin
        next_rdata[F_WRAP] = wrap_flag;
        next_rdata[F_MATCH+:NCH] = match_flag;
      end
      OFF_STATUS: begin
        next_rdata[S_STOP] = stop_st;
        next_rdata[S_BUSY] = busy;
      end
      OFF_COUNT: next_rdata = cnt;
      OFF_TOP: next_rdata = top_limit & MASK8;
      OFF_MATCH0: next_rdata = mgrab[0];
      OFF_MATCH1: next_rdata = mgrab[NCH-1];
      OFF_HALT: next_rdata[0] = dbg_keep;
      default: next_rdata = 32'h0;
    endcase
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cc_s1, cc_s2, cc_s3} <= 3'h0;
      {en_s1, en_s2, en_s3} <= 3'h0;
    end else begin
      {cc_s1, cc_s2, cc_s3} <= {core_count_clock, cc_s1, cc_s2};
      {en_s1, en_s2, en_s3} <= {en, en_s1, en_s2};
    end
  end

  // ----------------------------------------
  // main setup register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= 1'b0;
      keep_asleep <= 1'b0;
      mode <= MODE_16;
      wavegen <= WG_NFRQ;
      presc <= 3'h0;
      presync <= 1'b0;
    end else if (soft_reset_trigger) begin
      en <= 1'b0;
      keep_asleep <= 1'b0;
      mode <= MODE_16;
      wavegen <= WG_NFRQ;
      presc <= 3'h0;
      presync <= 1'b0;
    end else if (w_main) begin
      en <= wd[M_EN];
      keep_asleep <= wd[M_ASLEEP];
      if (prot_ok) begin
        mode <= wd[M_MODE+:2];
        wavegen <= wd[M_WAVE+:2];
        presc <= wd[M_PRE+:3];
        presync <= wd[M_PRESYNC];
      end
    end
  end

  // ----------------------------------------
  // other setup registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {dir, single_run_select} <= 2'h0;
      {flip, grab} <= '0;
      {act, ev_in_en, wrap_oe} <= 5'h0;
      match_oe <= '0;
      top_limit <= TOP_RST;
    end else if (soft_reset_trigger) begin
      {dir, single_run_select} <= 2'h0;
      {flip, grab} <= '0;
      {act, ev_in_en, wrap_oe} <= 5'h0;
      match_oe <= '0;
      top_limit <= TOP_RST;
    end else begin
      if (w_bset) begin
        dir <= dir | wd[B_DIR];
        single_run_select <= single_run_select | wd[B_SINGLE_RUN_SELECT];
      end else if (w_bclr) begin
        dir <= dir & ~wd[B_DIR];
        single_run_select <= single_run_select & ~wd[B_SINGLE_RUN_SELECT];
      end
      if (w_setc) begin
        flip <= wd[C_FLIP+:NCH];
        grab <= wd[C_GRAB+:NCH];
      end
      if (w_evset) begin
        if (prot_ok) begin
          act <= wd[E_ACT+:3];
        end
        ev_in_en <= wd[E_IN_EN];
        wrap_oe <= wd[E_WRAP_OE];
        match_oe <= wd[E_MATCH_OE+:NCH];
      end
      if (w_top) begin
        top_limit <= wd & MASK8;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_keep <= 1'b0;
    end else if (w_halt) begin
      dbg_keep <= wd[0];
    end
  end

  // ----------------------------------------
  // counter, prescaler, channels
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs <= CS_OFF;
      cnt <= 32'h0;
      pre_cnt <= '0;
      mgrab <= '0;
      wave <= '0;
    end else begin
      cs <= next_cs;
      cnt <= next_cnt;
      mgrab <= next_mgrab;
      wave <= next_wave;
      if (soft_reset_trigger || !running || (wrap && presync)) begin
        pre_cnt <= '0;
      end else if (cc_edge && !stall) begin
        pre_cnt <= pre_hit ? '0 : pre_cnt + 10'h1;
      end
    end
  end

  // ----------------------------------------
  // flags, status and outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrap_flag <= 1'b0;
      match_flag <= '0;
      stop_st <= 1'b0;
      rd_data <= 32'h0;
      shaped_output_pin <= '0;
      irq <= 1'b0;
      dma_req <= 1'b0;
      evt_wrap_out <= 1'b0;
      evt_match_out <= '0;
    end else begin
      wrap_flag <= !soft_reset_trigger && (wrap || (wrap_flag && !(w_flag && wd[F_WRAP])));
      match_flag <= next_mflag;
      stop_st <= !soft_reset_trigger && (next_cs == CS_WAIT && (sw_stop || stop_st || wrap));
      rd_data <= bus.rd ? next_rdata : 32'h0;
      shaped_output_pin <= next_wave ^ flip;
      irq <= wrap || (|(hit | capt)) || wrap_flag || (|match_flag);
      dma_req <= wrap || capt[0];
      evt_wrap_out <= wrap && wrap_oe;
      evt_match_out <= (hit | capt) & match_oe;
    end
  end
endmodule : tu_tally_unit
`default_nettype wire

/* sim/tu_fabric_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tu_fabric_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic ev_fire,
  output logic core_count_clock,
  output logic trig_event_in
);
  // ----------------
  // count clock and event source
  // ----------------
  logic [1:0] ph;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      core_count_clock <= 1'b0;
      trig_event_in <= 1'b0;
    end else begin
      trig_event_in <= ev_fire;
      ph <= run ? ph + 2'h1 : 2'h0;
      core_count_clock <= run & ph[1];
    end
  end
endmodule : tu_fabric_model
`default_nettype wire

/* sim/tu_tally_unit_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tu_tally_unit_props #(
  parameter int NCH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire tu_pkg::tu_bus_req_t bus,
  input wire logic [31:0] rd_data,
  input wire logic write_guard_on,
  input wire logic debug_halted,
  input wire logic [NCH-1:0] shaped_output_pin,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic evt_wrap_out,
  input wire logic [NCH-1:0] evt_match_out
);
  import tu_pkg::*;
  // ----------------
  // port checks
  // ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence soft_rst_wr;
    bus.wr && bus.addr == OFF_MAIN && bus.wdata[M_SOFT_RESET_TRIGGER]
      && (!write_guard_on || debug_halted || bus.dbg);
  endsequence
  sequence all_quiet;
    shaped_output_pin == '0 && !irq && !dma_req;
  endsequence
  rd_idle_a: assert property (!bus.rd |=> rd_data == 32'h0)
    else $error("read data not idle");
  halt_read_a: assert property (bus.rd && bus.addr == OFF_HALT |=> rd_data[31:1] == 31'h0)
    else $error("halt reserved bits set");
  soft_rst_a: assert property (soft_rst_wr |=> ##1 all_quiet)
    else $error("outputs active after soft reset");
  wrap_pulse_a: assert property (evt_wrap_out |=> !evt_wrap_out)
    else $error("wrap event too long");
  dma_pulse_a: assert property (dma_req |=> !dma_req)
    else $error("dma request too long");
  wrap_dma_a: assert property (evt_wrap_out |-> dma_req)
    else $error("wrap without dma request");
  wrap_irq_a: assert property (evt_wrap_out |-> ##[0:2] irq)
    else $error("wrap without interrupt");
  match_irq_a: assert property (|evt_match_out |-> ##[0:2] irq)
    else $error("match without interrupt");
endmodule : tu_tally_unit_props
bind tu_tally_unit tu_tally_unit_props #(.NCH(NCH)) i_tu_tally_unit_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .bus(bus), .rd_data(rd_data), .write_guard_on(write_guard_on),
  .debug_halted(debug_halted), .shaped_output_pin(shaped_output_pin), .irq(irq),
  .dma_req(dma_req), .evt_wrap_out(evt_wrap_out), .evt_match_out(evt_match_out));
`default_nettype wire

/* sim/tu_tally_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module tu_tally_unit_test;
  import tu_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  tu_bus_req_t bus = '0;
  logic [31:0] rd_data, v, c0;
  logic core_count_clock, trig_event_in, irq, dma_req, evt_wrap_out;
  logic write_guard_on = 1'b0;
  logic debug_halted = 1'b0;
  logic sleep_active = 1'b0;
  logic run = 1'b0;
  logic ev_fire = 1'b0;
  logic [1:0] shaped_output_pin, evt_match_out;
  logic [15:0] seed = 16'h005d;
  int failures = 0;
  int n_checks = 0;
  int i, top, nw, ntg;
  initial forever #20 ref_clk = ~ref_clk;
  tu_tally_unit #(.NCH(2)) i_tu_tally_unit (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
    .rd_data(rd_data), .core_count_clock(core_count_clock), .trig_event_in(trig_event_in),
    .write_guard_on(write_guard_on), .debug_halted(debug_halted),
    .sleep_active(sleep_active), .shaped_output_pin(shaped_output_pin), .irq(irq),
    .dma_req(dma_req), .evt_wrap_out(evt_wrap_out), .evt_match_out(evt_match_out));
  tu_fabric_model i_tu_fabric_model (.ref_clk(ref_clk), .rst_n(rst_n), .run(run),
    .ev_fire(ev_fire), .core_count_clock(core_count_clock), .trig_event_in(trig_event_in));
  // ----------------
  // helpers
  // ----------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic int gap(input int t, input int pre);
    int ratio[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
    return (t + 1) * ratio[pre] * 4;
  endfunction : gap
  function automatic logic [31:0] mainw(input int pre, input logic [1:0] md, input logic asl);
    return 32'h2 | (32'(pre) << M_PRE) | (32'(md) << M_MODE) | (32'(asl) << M_ASLEEP);
  endfunction : mainw
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic dbg = 1'b0);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0, dbg};
    @(posedge ref_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rd_data;
  endtask : rd
  task automatic watch(input int cyc);
    logic [1:0] p;
    p = shaped_output_pin;
    nw = 0;
    ntg = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      #1 nw += (evt_wrap_out === 1'b1);
      ntg += (shaped_output_pin[0] !== p[0]) + (shaped_output_pin[1] !== p[1]);
      p = shaped_output_pin;
    end
  endtask : watch
  task automatic wait_wrap();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1 k++;
    end while (evt_wrap_out !== 1'b1 && k < 3000);
    `CHK(evt_wrap_out, 1'b1)
  endtask : wait_wrap
  task automatic sync_wait();
    for (int k = 0; k < 20; k++) begin
      rd(OFF_STATUS, v);
      if (v[S_BUSY] === 1'b0) break;
    end
    `CHK(v[S_BUSY], 1'b0)
  endtask : sync_wait
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end
  // ----------------
  // scenarios
  // ----------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFF_MAIN, v);
    `CHK(v[M_MODE +: 2], MODE_16)
    write_guard_on <= 1'b1;
    for (i = 0; i < 4; i++) begin
      debug_halted <= i[1];
      wr(OFF_HALT, 32'h1, i[0]);
      rd(OFF_HALT, v);
      `CHK(v[0], i != 0)
      wr(OFF_HALT, 32'h0, 1'b1);
    end
    debug_halted <= 1'b0;
    seed = lfsr(seed);
    wr(OFF_COUNT, {16'h0, seed});
    rd(OFF_COUNT, v);
    `CHK(v, {16'h0, seed})
    write_guard_on <= 1'b0;
    wr(OFF_HALT, 32'h1);
    wr(OFF_TOP, 32'h33);
    wr(OFF_MAIN, 32'h1);
    rd(OFF_HALT, v);
    `CHK(v, 32'h1)
    rd(OFF_TOP, v);
    `CHK(v, TOP_RST)
    wr(OFF_HALT, 32'h0);
    wr(OFF_EVSET, 32'h100);
    run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      top = 3 + seed[2:0];
      wr(OFF_TOP, 32'(top));
      wr(OFF_MAIN, mainw(i, MODE_8, 1'b0));
      wait_wrap();
      wr(OFF_MAIN, mainw(i ^ 1, MODE_8, 1'b0));
      wait_wrap();
      watch(3 * gap(top, i));
      `CHK(nw, 3)
      wr(OFF_MAIN, 32'h0);
      sync_wait();
      rd(OFF_MAIN, v);
      `CHK(v[M_PRE +: 3], 3'(i))
    end
    wr(OFF_SETB_SET, 32'h1);
    wr(OFF_MAIN, mainw(0, MODE_8, 1'b0));
    wait_wrap();
    rd(OFF_COUNT, v);
    `CHK(v, 32'(top))
    wr(OFF_SETB_CLR, 32'h1);
    wr(OFF_SETB_SET, 32'h4);
    wait_wrap();
    watch(2 * gap(top, 0));
    `CHK(nw, 0)
    rd(OFF_STATUS, v);
    `CHK(v[S_STOP], 1'b1)
    rd(OFF_FLAG, v);
    `CHK(v[F_WRAP], 1'b1)
    `CHK(irq, 1'b1)
    wr(OFF_FLAG, 32'h31);
    rd(OFF_FLAG, v);
    `CHK(v[F_WRAP], 1'b0)
    `CHK(irq, 1'b0)
    wr(OFF_SETB_CLR, 32'h4);
    wr(OFF_SETB_SET, 32'(CMD_RETRIG) << B_CMD);
    wr(OFF_EVSET, 32'h104);
    rd(OFF_EVSET, v);
    `CHK(v[E_ACT +: 3], ACT_OFF)
    for (i = 0; i < 4; i++) begin
      debug_halted <= !i[1];
      sleep_active <= i[1];
      wr(OFF_HALT, 32'(i[0]));
      wr(OFF_MAIN, mainw(0, MODE_8, i[0]));
      watch(2 * gap(top, 0));
      `CHK(nw, 2 * i[0])
    end
    debug_halted <= 1'b0;
    sleep_active <= 1'b0;
    wr(OFF_MAIN, 32'h0);
    sync_wait();
    wr(OFF_MAIN, 32'h1);
    wr(OFF_SETC, 32'h3);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(shaped_output_pin, 2'b11)
    wr(OFF_TOP, 32'(top));
    wr(OFF_EVSET, 32'h3100);
    wr(OFF_MATCH0, 32'h1);
    wr(OFF_MATCH1, 32'h2);
    wr(OFF_MAIN, mainw(0, MODE_8, 1'b0));
    wait_wrap();
    watch(2 * gap(top, 0));
    `CHK(ntg, 4)
    run <= 1'b0;
    wr(OFF_MAIN, 32'h0);
    sync_wait();
    for (i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      c0 = {i ? ~seed : 16'h0, seed};
      wr(OFF_EVSET, i ? 32'h2014 : 32'h12);
      wr(OFF_SETC, 32'h20);
      wr(OFF_MAIN, mainw(0, i ? MODE_32 : MODE_16, 1'b0));
      wr(OFF_COUNT, c0);
      sync_wait();
      ev_fire <= 1'b1;
      repeat (5) @(posedge ref_clk);
      ev_fire <= 1'b0;
      rd(i ? OFF_MATCH1 : OFF_COUNT, v);
      `CHK(v, i ? c0 : (c0 + 32'h5) & MASK16)
      wr(OFF_MAIN, 32'h0);
      sync_wait();
    end
    print_verdict();
  end
endmodule : tu_tally_unit_test
`default_nettype wire
